// *** rtl/updown_counter_pkg.sv ***
// Constants shared by the up/down counter block
package updown_counter_pkg;
    localparam int unsigned CNT_W = 16;

    // Count clock source and divider / external mode select
    localparam logic [1:0] CS_DIV4  = 2'h0;
    localparam logic [1:0] CS_DIV8  = 2'h1;
    localparam logic [1:0] CS_DIV16 = 2'h2;
    localparam logic [1:0] CS_MODE1 = 2'h0;
    localparam logic [1:0] CS_MODE2 = 2'h1;
    localparam logic [1:0] CS_MODE3 = 2'h2;
    localparam logic [1:0] CS_MODE4 = 2'h3;

    // Prescaler divisors and the tick masks derived from them
    localparam int unsigned PRE_W    = 4;
    localparam int unsigned DIV_A    = 4;
    localparam int unsigned DIV_B    = 8;
    localparam int unsigned DIV_C    = 16;
    localparam logic [3:0] MASK_DIV4  = 4'(DIV_A - 1);
    localparam logic [3:0] MASK_DIV8  = 4'(DIV_B - 1);
    localparam logic [3:0] MASK_DIV16 = 4'(DIV_C - 1);

    // Active edge of the count input
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_NONE = 2'h3;

    // Reset values
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [3:0]  PRE_RST  = 4'h0;
    localparam logic        FLAG_RST = 1'b0;
endpackage

// *** rtl/pin_edge_sync.sv ***
// Two-stage pin synchroniser with rise and fall detection
`timescale 1ns/10ps
module pin_edge_sync (
    input  wire logic ref_clk_in,  // System clock
    input  wire logic rst_in,      // Async reset, high
    input  wire logic pin_in,      // Raw pin level
    output logic      level_out,   // Synchronised level
    output logic      rise_out,    // One-cycle rise pulse
    output logic      fall_out     // One-cycle fall pulse
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level_out = sync_ff;
    assign rise_out  = sync_ff & ~last_ff;
    assign fall_out  = ~sync_ff & last_ff;
endmodule

// *** rtl/quadrature_up_down_counter.sv ***
// Up/down counter with prescaler, four external modes and compare matches
//
// How it works
// - Counter is sixteen bits, serving as interval, free-running or event counter.
// - Internal source steps the counter every 4, 8 or 16 system clocks.
// - Internal clock uses the direction bit; external clock takes direction from pins.
// - Counting past the maximum sets the sticky overflow flag.
// - Counting below zero sets the sticky underflow flag.
// - External clear pin forces the counter to zero in every mode.
// - Enable held at one keeps counting without any restart.
// - Enable at zero clears the counter and halts it.
// - Reset clears the counter; it counts on at once if enable is still high.
// - Both compare registers are watched; each equality pulses its own request.
// - Modulo bit zero selects normal counting, one selects modulo counting.
// - Normal mode overflow or underflow returns the counter to zero.
// - Modulo up-count matching compare 0 clears the counter on next step.
// - Modulo down-count underflow reloads the counter from compare 0.
// - With external clock, select field codes 00 to 11 pick modes 1 to 4.
// - Mode 1: active count edge counts down if direction high, else up.
// - Mode 2: count edge counts up, direction rising edge counts down.
// - Mode 2: simultaneous count and direction edges leave the counter unchanged.
// - Mode 3: on count edge, direction low counts down, high counts up.
// - Mode 4: a lone edge of either input steps, direction from their phase; edges on both in one cycle do not step.
// - Mode 4 ignores the programmed count-input edge selection.
// - Modes 1 to 3 use the programmed count-input edge.
`timescale 1ns/10ps
module quadrature_up_down_counter #(
    parameter int unsigned CNT_W = updown_counter_pkg::CNT_W
) (
    input  wire logic             ref_clk_in,           // System clock, 250 MHz
    input  wire logic             rst_in,               // Async reset, high
    input  wire logic             count_enable_bit_in,  // Counting enable level
    input  wire logic             direction_bit_in,     // 1 counts down (internal clock)
    input  wire logic             modulo_enable_bit_in, // 1 selects modulo mode
    input  wire logic             external_sel_in,      // 1 selects external count clock
    input  wire logic [1:0]       clock_select_in,      // Divider or external mode
    input  wire logic [1:0]       edge_select_in,       // Active count-input edge
    input  wire logic [CNT_W-1:0] compare_reg_0_in,     // Compare register 0
    input  wire logic [CNT_W-1:0] compare_reg_1_in,     // Compare register 1
    input  wire logic             count_input_pin_in,   // External count / phase A
    input  wire logic             direction_input_pin_in, // Direction / phase B
    input  wire logic             external_clear_pin_in,  // Clear, active high
    input  wire logic             overflow_clr_in,      // Clears overflow flag
    input  wire logic             underflow_clr_in,     // Clears underflow flag
    output logic [CNT_W-1:0]      updown_counter_out,   // Counter value
    output logic                  overflow_flag_out,    // Sticky overflow
    output logic                  underflow_flag_out,   // Sticky underflow
    output logic                  compare0_match_irq_out, // Match pulse, compare 0
    output logic                  compare1_match_irq_out  // Match pulse, compare 1
);
    import updown_counter_pkg::*;

    if (CNT_W < 4 || CNT_W > 32) begin : g_bad_width
        $error("CNT_W must lie between 4 and 32");
    end

    localparam logic [CNT_W-1:0] CNT_MAX  = '1;
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    logic [CNT_W-1:0] cnt_ff;
    logic [PRE_W-1:0] pre_ff;
    logic             ovf_ff;
    logic             udf_ff;
    logic             irq0_ff;
    logic             irq1_ff;

    logic a_lvl, a_rise, a_fall;
    logic b_lvl, b_rise, b_fall;
    logic clr_lvl;
    logic [3:0] pre_mask;
    logic pre_tick;
    logic a_act;
    logic up_step;
    logic dn_step;
    logic [CNT_W-1:0] nxt_cnt;
    logic nxt_ovf;
    logic nxt_udf;
    logic hold_zero;

    // Pin inputs synchronised before any use
    pin_edge_sync u_sync_cnt (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .pin_in     (count_input_pin_in),
        .level_out  (a_lvl),
        .rise_out   (a_rise),
        .fall_out   (a_fall)
    );

    pin_edge_sync u_sync_dir (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .pin_in     (direction_input_pin_in),
        .level_out  (b_lvl),
        .rise_out   (b_rise),
        .fall_out   (b_fall)
    );

    pin_edge_sync u_sync_clr (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .pin_in     (external_clear_pin_in),
        .level_out  (clr_lvl),
        .rise_out   (),
        .fall_out   ()
    );

    // Prescaler tick selection; code 11 gives no internal count
    always_comb begin
        unique case (clock_select_in)
            CS_DIV4:  pre_mask = MASK_DIV4;
            CS_DIV8:  pre_mask = MASK_DIV8;
            CS_DIV16: pre_mask = MASK_DIV16;
            default:  pre_mask = 4'hf;
        endcase
    end

    assign pre_tick = ((pre_ff & pre_mask) == pre_mask) && (clock_select_in != CS_MODE4);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_ff <= PRE_RST;
        end else if (!count_enable_bit_in || external_sel_in) begin
            pre_ff <= PRE_RST;
        end else begin
            pre_ff <= pre_ff + 4'h1;
        end
    end

    // Active edge of the count input for modes 1 to 3
    always_comb begin
        unique case (edge_select_in)
            EDGE_FALL: a_act = a_fall;
            EDGE_RISE: a_act = a_rise;
            EDGE_BOTH: a_act = a_rise | a_fall;
            EDGE_NONE: a_act = 1'b0;
        endcase
    end

    // Step direction from the selected source
    always_comb begin
        up_step = 1'b0;
        dn_step = 1'b0;
        if (!external_sel_in) begin
            up_step = pre_tick && !direction_bit_in;
            dn_step = pre_tick && direction_bit_in;
        end else begin
            unique case (clock_select_in)
                CS_MODE1: begin
                    up_step = a_act && !b_lvl;
                    dn_step = a_act && b_lvl;
                end
                CS_MODE2: begin
                    up_step = a_act && !b_rise;
                    dn_step = b_rise && !a_act;
                end
                CS_MODE3: begin
                    up_step = a_act && b_lvl;
                    dn_step = a_act && !b_lvl;
                end
                CS_MODE4: begin
                    // Edge select is not consulted here
                    up_step = (a_rise && !b_lvl) || (a_fall && b_lvl) ||
                              (b_rise && a_lvl) || (b_fall && !a_lvl);
                    dn_step = (a_rise && b_lvl) || (a_fall && !b_lvl) ||
                              (b_rise && !a_lvl) || (b_fall && a_lvl);
                    if (up_step && dn_step) begin
                        up_step = 1'b0;
                        dn_step = 1'b0;
                    end
                end
            endcase
        end
    end

    assign hold_zero = !count_enable_bit_in || clr_lvl;

    // Next counter value, wrap, modulo and flag events
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_ovf = 1'b0;
        nxt_udf = 1'b0;
        if (hold_zero) begin
            nxt_cnt = CNT_ZERO;
        end else if (up_step) begin
            if (modulo_enable_bit_in && cnt_ff == compare_reg_0_in) begin
                nxt_cnt = CNT_ZERO;
            end else if (cnt_ff == CNT_MAX) begin
                nxt_cnt = CNT_ZERO;
                nxt_ovf = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end else if (dn_step) begin
            if (cnt_ff == CNT_ZERO) begin
                nxt_udf = 1'b1;
                nxt_cnt = modulo_enable_bit_in ? compare_reg_0_in : CNT_ZERO;
            end else begin
                nxt_cnt = cnt_ff - 1'b1;
            end
        end
    end

    // Counter register; an enable held high never restarts it
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= CNT_ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ovf_ff <= FLAG_RST;
            udf_ff <= FLAG_RST;
        end else begin
            ovf_ff <= nxt_ovf || (ovf_ff && !overflow_clr_in);
            udf_ff <= nxt_udf || (udf_ff && !underflow_clr_in);
        end
    end

    // Match requests pulse when the counter moves onto a compare value
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq0_ff <= FLAG_RST;
            irq1_ff <= FLAG_RST;
        end else begin
            irq0_ff <= (nxt_cnt != cnt_ff) && (nxt_cnt == compare_reg_0_in);
            irq1_ff <= (nxt_cnt != cnt_ff) && (nxt_cnt == compare_reg_1_in);
        end
    end

    assign updown_counter_out     = cnt_ff;
    assign overflow_flag_out      = ovf_ff;
    assign underflow_flag_out     = udf_ff;
    assign compare0_match_irq_out = irq0_ff;
    assign compare1_match_irq_out = irq1_ff;

    a_ce_low_clears: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !count_enable_bit_in |=> cnt_ff == CNT_ZERO)
        else $error("counter not cleared while disabled");

    a_clear_pin_zero: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clr_lvl |=> cnt_ff == CNT_ZERO)
        else $error("clear pin did not zero the counter");

    a_ovf_sets_flag: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (!hold_zero && up_step && cnt_ff == CNT_MAX && !modulo_enable_bit_in)
        |=> ovf_ff && cnt_ff == CNT_ZERO)
        else $error("overflow did not wrap and flag");

    a_udf_sets_flag: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (!hold_zero && dn_step && cnt_ff == CNT_ZERO) |=> udf_ff)
        else $error("underflow flag not set");

    a_norm_udf_zero: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (!hold_zero && dn_step && cnt_ff == CNT_ZERO && !modulo_enable_bit_in)
        |=> cnt_ff == CNT_ZERO)
        else $error("normal underflow did not return to zero");

    a_mod_match_clear: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (!hold_zero && up_step && modulo_enable_bit_in && cnt_ff == compare_reg_0_in)
        |=> cnt_ff == CNT_ZERO)
        else $error("modulo match did not clear");

    a_mod_reload: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (!hold_zero && dn_step && modulo_enable_bit_in && cnt_ff == CNT_ZERO)
        |=> cnt_ff == $past(compare_reg_0_in))
        else $error("modulo underflow did not reload");

    a_cmp1_match_pulse: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        irq1_ff |-> cnt_ff == $past(compare_reg_1_in) && cnt_ff != $past(cnt_ff))
        else $error("compare 1 request without a match");

    a_cmp0_match_pulse: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        irq0_ff |-> cnt_ff == $past(compare_reg_0_in) && cnt_ff != $past(cnt_ff))
        else $error("compare 0 request without a match");

    a_mode3_dir: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (external_sel_in && clock_select_in == CS_MODE3 && a_act && b_lvl && !hold_zero
         && cnt_ff != CNT_MAX) |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("mode 3 did not count up");

    a_mode2_both_hold: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (external_sel_in && clock_select_in == CS_MODE2 && a_act && b_rise && !hold_zero)
        |=> $stable(cnt_ff))
        else $error("mode 2 moved on simultaneous edges");

    a_div4_spacing: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (!external_sel_in && clock_select_in == CS_DIV4 && (up_step || dn_step))
        |=> (!(up_step || dn_step) || clock_select_in != CS_DIV4 || external_sel_in)[*3])
        else $error("divide-by-4 stepped too early");

    a_mode1_dir: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (external_sel_in && clock_select_in == CS_MODE1 && a_act && b_lvl && !hold_zero
         && cnt_ff != CNT_ZERO) |=> cnt_ff == $past(cnt_ff) - 1'b1)
        else $error("mode 1 did not count down");
endmodule

// *** verification/encoder_model.sv ***
// Behavioural shaft encoder and event source that drives the counter pins
`timescale 1ns/10ps
module encoder_model (
    input  wire logic ref_clk_in,  // System clock
    output logic      phase_a_out, // Count input pin
    output logic      phase_b_out  // Direction input pin
);
    initial begin
        phase_a_out = 1'b0;
        phase_b_out = 1'b0;
    end

    // Each level is held six clocks so the synchroniser never misses it
    task automatic drive(input logic a, input logic b);
        @(negedge ref_clk_in);
        phase_a_out = a;
        phase_b_out = b;
        repeat (6) @(negedge ref_clk_in);
    endtask

    // One quarter step of the quadrature pattern; only one phase moves at a time
    task automatic quad(input logic up);
        if (up) begin
            drive(~phase_b_out, phase_a_out);
        end else begin
            drive(phase_b_out, ~phase_a_out);
        end
    endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the quadrature up/down counter
`timescale 1ns/10ps
module tb;
    import updown_counter_pkg::*;
    logic        ref_clk_in, rst_in, en, dir, mod, ext, clr, oclr, uclr;
    logic [1:0]  csel, esel;
    logic [15:0] cmp0, cmp1, cnt, irq0_n, irq1_n;
    logic        ovf, udf, irq0, irq1, pin_a, pin_b;
    int          err_total = 0;
    int          check_count = 0;
    int          cycles = 0;

    quadrature_up_down_counter dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .count_enable_bit_in(en), .direction_bit_in(dir),
        .modulo_enable_bit_in(mod), .external_sel_in(ext), .clock_select_in(csel), .edge_select_in(esel),
        .compare_reg_0_in(cmp0), .compare_reg_1_in(cmp1), .count_input_pin_in(pin_a),
        .direction_input_pin_in(pin_b), .external_clear_pin_in(clr), .overflow_clr_in(oclr),
        .underflow_clr_in(uclr), .updown_counter_out(cnt), .overflow_flag_out(ovf),
        .underflow_flag_out(udf), .compare0_match_irq_out(irq0), .compare1_match_irq_out(irq1));
    encoder_model enc (.ref_clk_in(ref_clk_in), .phase_a_out(pin_a), .phase_b_out(pin_b));

    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    // Match pulses stand one cycle, so they are tallied at every edge
    always @(posedge ref_clk_in) begin
        cycles++;
        if (irq0 === 1'b1) irq0_n <= irq0_n + 16'h0001;
        if (irq1 === 1'b1) irq1_n <= irq1_n + 16'h0001;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask

    task automatic wait_chg(output int n);
        logic [15:0] v;
        v = cnt;
        n = 0;
        while (cnt === v && n < 200) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic restart;
        en = 1'b0;
        cyc(2);
        en = 1'b1;
    endtask

    task automatic pstep(input logic a, input logic b, input logic [15:0] exp);
        enc.drive(a, b);
        chk(cnt, exp);
    endtask

    task automatic t_prescale;
        int n;
        for (int i = 0; i < 3; i++) begin
            csel = 2'(i);
            restart();
            wait_chg(n);
            wait_chg(n);
            chk(16'(n), 16'(4 << i));
            chk(cnt, 16'h0002);
        end
        $display("test prescale done");
    endtask

    task automatic t_flags;
        int n;
        csel = CS_DIV4;
        cmp0 = 16'hffff;
        mod = 1'b1;
        dir = 1'b1;
        restart();
        wait_chg(n);
        chk(cnt, 16'hffff);
        chk(16'(udf), 16'h0001);
        uclr = 1'b1;
        cyc(1);
        uclr = 1'b0;
        mod = 1'b0;
        dir = 1'b0;
        chk(16'(udf), 16'h0000);
        wait_chg(n);
        chk(cnt, 16'h0000);
        chk(16'(ovf), 16'h0001);
        oclr = 1'b1;
        cyc(1);
        oclr = 1'b0;
        chk(16'(ovf), 16'h0000);
        dir = 1'b1;
        cyc(9);
        chk(cnt, 16'h0000);
        chk(16'(udf), 16'h0001);
        $display("test flags done");
    endtask

    task automatic t_modulo;
        int n;
        cmp0 = 16'h0005;
        cmp1 = 16'h0003;
        mod = 1'b1;
        dir = 1'b0;
        en = 1'b0;
        cyc(2);
        irq0_n = 16'h0000;
        irq1_n = 16'h0000;
        en = 1'b1;
        cyc(46);
        chk(irq0_n, 16'h0002);
        chk(irq1_n, 16'h0002);
        while (cnt !== 16'h0005 && n < 200) begin
            cyc(1);
            n++;
        end
        wait_chg(n);
        chk(cnt, 16'h0000);
        mod = 1'b0;
        $display("test modulo done");
    endtask

    task automatic t_clear;
        restart();
        cyc(12);
        clr = 1'b1;
        cyc(5);
        chk(cnt, 16'h0000);
        cyc(8);
        chk(cnt, 16'h0000);
        clr = 1'b0;
        cyc(12);
        chk(16'(cnt !== 16'h0000), 16'h0001);
        en = 1'b0;
        cyc(2);
        chk(cnt, 16'h0000);
        $display("test clear done");
    endtask

    task automatic t_external;
        enc.drive(1'b0, 1'b0);
        ext = 1'b1;
        csel = CS_MODE1;
        esel = EDGE_RISE;
        restart();
        pstep(1'b1, 1'b0, 16'h0001);
        pstep(1'b0, 1'b0, 16'h0001);
        pstep(1'b0, 1'b1, 16'h0001);
        pstep(1'b1, 1'b1, 16'h0000);
        esel = EDGE_FALL;
        pstep(1'b1, 1'b0, 16'h0000);
        pstep(1'b0, 1'b0, 16'h0001);
        csel = CS_MODE2;
        esel = EDGE_RISE;
        restart();
        pstep(1'b1, 1'b0, 16'h0001);
        pstep(1'b0, 1'b0, 16'h0001);
        pstep(1'b0, 1'b1, 16'h0000);
        pstep(1'b0, 1'b0, 16'h0000);
        pstep(1'b1, 1'b0, 16'h0001);
        pstep(1'b0, 1'b0, 16'h0001);
        pstep(1'b1, 1'b1, 16'h0001);
        enc.drive(1'b0, 1'b0);
        csel = CS_MODE3;
        restart();
        pstep(1'b0, 1'b1, 16'h0000);
        pstep(1'b1, 1'b1, 16'h0001);
        pstep(1'b0, 1'b0, 16'h0001);
        pstep(1'b1, 1'b0, 16'h0000);
        enc.drive(1'b0, 1'b0);
        csel = CS_MODE4;
        esel = EDGE_NONE;
        restart();
        repeat (4) enc.quad(1'b1);
        chk(cnt, 16'h0004);
        repeat (2) enc.quad(1'b0);
        chk(cnt, 16'h0002);
        $display("test external done");
    endtask

    task automatic t_reset;
        ext = 1'b0;
        csel = CS_DIV4;
        restart();
        cyc(10);
        rst_in = 1'b1;
        cyc(1);
        chk(cnt, 16'h0000);
        chk(16'(ovf), 16'h0000);
        en = 1'b0;
        rst_in = 1'b0;
        cyc(20);
        chk(cnt, 16'h0000);
        $display("test reset done");
    endtask

    initial begin
        {en, dir, mod, ext, clr, oclr, uclr} = 7'h00;
        csel = CS_DIV4;
        esel = EDGE_RISE;
        cmp0 = 16'h0000;
        cmp1 = 16'h0000;
        irq0_n = 16'h0000;
        irq1_n = 16'h0000;
        rst_in = 1'b1;
        cyc(4);
        rst_in = 1'b0;
        cyc(1);
        chk(cnt, 16'h0000);
        t_prescale();
        t_flags();
        t_modulo();
        t_clear();
        t_external();
        t_reset();
        summarize();
    end
endmodule
